// file: hdl/arcs_pkg.sv
// Constants, register map and field layout of the accumulating converter back end
// What this block does
// RULE1: With left alignment off each result is stored right-aligned, low eight bits in the low byte.
// RULE2: With left alignment on the result is shifted up so its top eight bits sit in the high byte.
// RULE3: Results of 1, 2, 4, 8, 16, 32, 64 or 128 consecutive conversions are summed into one value.
// RULE4: Sums of more than 16 samples lose their low bits so that the stored value fits 16 bits.
// RULE5: Single-ended sums of 1 to 8 samples are 12 to 15 bits, zero-filled above or below.
// RULE6: For 16 samples or more all 16 result bits are used and alignment has no effect.
// RULE7: Differential sums are placed the same way, with the sign copied into unused upper bits.
// RULE8: Single-ended conversions use only the positive selection, differential ones use both.
// RULE9: Input selections pass through a holding register before they reach the multiplexer.
// RULE10: While idle the holding register keeps copying the written selections.
// RULE11: From the start of a conversion the applied selections are frozen.
// RULE12: Copying resumes in the last converter-clock cycle before the conversion completes.
// RULE13: A start written by software begins on the next rising converter-clock edge.
// RULE14: A finished conversion or accumulation loads the result register and sets the ready flag.
// RULE15: During accumulation the start bit stays set until all samples are taken.
// RULE16: The accumulator is cleared at the start of each new accumulated conversion.
package arcs_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CONTROL_A = 8'h00;
  localparam logic [7:0] OFS_CONTROL_B = 8'h04;
  localparam logic [7:0] OFS_PRESCALE = 8'h08;
  localparam logic [7:0] OFS_POS_SELECT = 8'h0C;
  localparam logic [7:0] OFS_NEG_SELECT = 8'h10;
  localparam logic [7:0] OFS_COMMAND = 8'h14;
  localparam logic [7:0] OFS_RESULT = 8'h18;
  localparam logic [7:0] OFS_INT_STATUS = 8'h1C;
  localparam logic [7:0] OFS_INT_MASK = 8'h20;

  // ==========================================================================
  // Field positions and widths
  localparam int BIT_LEFT_ALIGN = 0;
  localparam int BIT_DIFF_MODE = 1;
  localparam int BIT_START = 0;
  localparam int BIT_RES_READY = 0;
  localparam int SEL_W = 7;
  localparam int CNT_SEL_W = 3;
  localparam int PRESC_W = 3;
  localparam int RAW_W = 12;
  localparam int RES_W = 16;
  localparam int ACC_W = 19;
  localparam int NO_TRUNC_LOG2 = 4;

  // ==========================================================================
  // Reset values and conversion timing in converter-clock cycles
  localparam logic [SEL_W-1:0] SEL_RESET = 7'h00;
  localparam logic [SEL_W-1:0] NEG_UNUSED = 7'h00;
  localparam logic [CNT_SEL_W-1:0] CNT_SEL_RESET = 3'h0;
  localparam logic [PRESC_W-1:0] PRESC_RESET = 3'h0;
  localparam int SAMPLE_ADC_CYCLES = 2;
  localparam int CONV_ADC_CYCLES = 14;
  localparam int TOTAL_ADC_CYCLES = SAMPLE_ADC_CYCLES + CONV_ADC_CYCLES;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Widen a raw sample, sign-extending in differential mode
  function automatic logic [ACC_W-1:0] sample_ext(input logic [RAW_W-1:0] raw,
                                                  input logic diff);
    sample_ext = {{(ACC_W-RAW_W){diff & raw[RAW_W-1]}}, raw};
  endfunction

endpackage

// file: hdl/arcs_conv_if.sv
// Handshake between the register side and the conversion sequencer
`timescale 1ns/1ps
interface arcs_conv_if;
  logic start;
  logic [arcs_pkg::PRESC_W-1:0] presc;
  logic busy;
  logic hold_sel;
  logic sampling;
  logic done;

  modport ctrl (output start, output presc, input busy, input hold_sel, input sampling,
                input done);
  modport seq (input start, input presc, output busy, output hold_sel, output sampling,
               output done);
endinterface

// file: hdl/arcs_conv_seq.sv
// Converter clock prescaler and per-sample conversion timing
`timescale 1ns/1ps
module arcs_conv_seq (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control side
  arcs_conv_if.seq cif
);

  typedef enum logic [1:0] {S_IDLE, S_WAIT, S_RUN} arcs_seq_state_t;

  arcs_seq_state_t state;
  logic [7:0] div_cnt;
  logic [7:0] div_limit;
  logic [4:0] adc_cnt;
  logic adc_tick;

  // Prescaler held in reset while idle, so start latency is fixed
  assign div_limit = 8'((2 << cif.presc) - 1);
  assign adc_tick = (state != S_IDLE) && (div_cnt == div_limit);

  // ==========================================================================
  // Prescaler
  always_ff @(posedge aclk) begin
    if (!aresetn || state == S_IDLE || adc_tick) begin
      div_cnt <= 8'h00;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  // ==========================================================================
  // Sequence
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= S_IDLE;
      adc_cnt <= 5'h00;
      cif.done <= 1'b0;
    end else begin
      cif.done <= 1'b0;
      case (state)
        S_IDLE: begin
          if (cif.start) begin
            state <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (adc_tick) begin // RULE13
            state <= S_RUN;
            adc_cnt <= 5'h00;
          end
        end
        S_RUN: begin
          if (adc_tick) begin
            if (adc_cnt == 5'(arcs_pkg::TOTAL_ADC_CYCLES - 1)) begin
              state <= S_IDLE;
              cif.done <= 1'b1;
            end else begin
              adc_cnt <= adc_cnt + 5'h01;
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  assign cif.busy = (state != S_IDLE);
  // Released while idle and for the final converter cycle
  assign cif.hold_sel = (state == S_WAIT) ||
                        (state == S_RUN && adc_cnt < 5'(arcs_pkg::TOTAL_ADC_CYCLES - 1)); // RULE12
  assign cif.sampling = (state == S_RUN) && (adc_cnt < 5'(arcs_pkg::SAMPLE_ADC_CYCLES));

endmodule // arcs_conv_seq

// file: hdl/arcs_result_pack.sv
// Places an accumulated sum into the 16-bit result format
`timescale 1ns/1ps
module arcs_result_pack (
  // Sum and format
  input wire logic [arcs_pkg::ACC_W-1:0] sum,
  input wire logic [arcs_pkg::CNT_SEL_W-1:0] count_log2,
  input wire logic left_align,
  input wire logic diff,
  // Packed value
  output logic [arcs_pkg::RES_W-1:0] packed_result
);

  logic [arcs_pkg::ACC_W-1:0] shifted;

  always_comb begin
    shifted = sum;
    if (count_log2 > 3'(arcs_pkg::NO_TRUNC_LOG2)) begin
      // Drop low bits; sign kept for differential sums
      if (diff) begin
        shifted = $signed(sum) >>> (count_log2 - 3'(arcs_pkg::NO_TRUNC_LOG2)); // RULE4 RULE7
      end else begin
        shifted = sum >> (count_log2 - 3'(arcs_pkg::NO_TRUNC_LOG2)); // RULE4
      end
      packed_result = shifted[arcs_pkg::RES_W-1:0]; // RULE6
    end else if (left_align) begin
      packed_result = sum[arcs_pkg::RES_W-1:0] <<
                      (3'(arcs_pkg::NO_TRUNC_LOG2) - count_log2); // RULE2 RULE5 RULE6
    end else begin
      // Upper bits already zero or sign copies from widening
      packed_result = sum[arcs_pkg::RES_W-1:0]; // RULE1 RULE5 RULE7
    end
  end

endmodule // arcs_result_pack

// file: hdl/arcs_top.sv
// Accumulating converter back end: AXI4-Lite registers, accumulator, channel hold
`timescale 1ns/1ps
module arcs_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Analog front end
  input wire logic [arcs_pkg::RAW_W-1:0] analog_data,
  output logic [arcs_pkg::SEL_W-1:0] positive_input_select,
  output logic [arcs_pkg::SEL_W-1:0] negative_input_select,
  output logic analog_sample,
  // Interrupt
  output logic irq
);

  // ==========================================================================
  // Declarations
  arcs_conv_if cif ();

  logic result_left_align;
  logic diff_mode;
  logic [arcs_pkg::CNT_SEL_W-1:0] sample_count_select;
  logic [arcs_pkg::PRESC_W-1:0] prescale;
  logic [arcs_pkg::SEL_W-1:0] pos_select;
  logic [arcs_pkg::SEL_W-1:0] neg_select;
  logic conversion_start_bit;
  logic [arcs_pkg::RES_W-1:0] conversion_result;
  logic result_ready_flag;
  logic result_ready_mask;

  logic run_left;
  logic run_diff;
  logic [arcs_pkg::CNT_SEL_W-1:0] run_count_log2;
  logic [7:0] samples_left;
  logic [arcs_pkg::ACC_W-1:0] acc;
  logic [arcs_pkg::ACC_W-1:0] next_acc;
  logic [arcs_pkg::RES_W-1:0] packed_result;
  logic start_pulse;

  logic [arcs_pkg::RAW_W-1:0] data_meta;
  logic [arcs_pkg::RAW_W-1:0] data_sync;

  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_fire;
  logic wr_lane0;
  logic sw_start;
  logic rd_fire;
  logic rd_clear_flag;
  logic last_sample;

  // ==========================================================================
  // Sequencer and packer
  arcs_conv_seq u_seq (
    .aclk(aclk),
    .aresetn(aresetn),
    .cif(cif.seq)
  );

  arcs_result_pack u_pack (
    .sum(next_acc),
    .count_log2(run_count_log2),
    .left_align(run_left),
    .diff(run_diff),
    .packed_result(packed_result)
  );

  assign cif.start = start_pulse;
  assign cif.presc = prescale;

  // ==========================================================================
  // Analog data synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_meta <= '0;
      data_sync <= '0;
    end else begin
      data_meta <= analog_data;
      data_sync <= data_meta;
    end
  end

  // ==========================================================================
  // AXI4-Lite write path: address and data taken in either order
  assign wr_fire = aw_held && w_held && !bvalid;
  assign wr_lane0 = wr_fire && w_strb_q[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
    end else begin
      awready <= !aw_held && !awready && awvalid;
      wready <= !w_held && !wready && wvalid;
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_addr_q <= awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= arcs_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      case (aw_addr_q)
        arcs_pkg::OFS_CONTROL_A, arcs_pkg::OFS_CONTROL_B, arcs_pkg::OFS_PRESCALE,
        arcs_pkg::OFS_POS_SELECT, arcs_pkg::OFS_NEG_SELECT, arcs_pkg::OFS_COMMAND,
        arcs_pkg::OFS_RESULT, arcs_pkg::OFS_INT_STATUS, arcs_pkg::OFS_INT_MASK: begin
          bresp <= arcs_pkg::RESP_OKAY;
        end
        default: bresp <= arcs_pkg::RESP_SLVERR;
      endcase
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // Configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_left_align <= 1'b0;
      diff_mode <= 1'b0;
      sample_count_select <= arcs_pkg::CNT_SEL_RESET;
      prescale <= arcs_pkg::PRESC_RESET;
      pos_select <= arcs_pkg::SEL_RESET;
      neg_select <= arcs_pkg::SEL_RESET;
      result_ready_mask <= 1'b0;
    end else if (wr_lane0) begin
      case (aw_addr_q)
        arcs_pkg::OFS_CONTROL_A: begin
          result_left_align <= w_data_q[arcs_pkg::BIT_LEFT_ALIGN];
          diff_mode <= w_data_q[arcs_pkg::BIT_DIFF_MODE];
        end
        arcs_pkg::OFS_CONTROL_B: sample_count_select <= w_data_q[arcs_pkg::CNT_SEL_W-1:0];
        arcs_pkg::OFS_PRESCALE: prescale <= w_data_q[arcs_pkg::PRESC_W-1:0];
        arcs_pkg::OFS_POS_SELECT: pos_select <= w_data_q[arcs_pkg::SEL_W-1:0];
        arcs_pkg::OFS_NEG_SELECT: neg_select <= w_data_q[arcs_pkg::SEL_W-1:0];
        arcs_pkg::OFS_INT_MASK: result_ready_mask <= w_data_q[arcs_pkg::BIT_RES_READY];
        default: ;
      endcase
    end
  end

  // Start while busy is ignored; one accumulation at a time
  assign sw_start = wr_lane0 && (aw_addr_q == arcs_pkg::OFS_COMMAND) &&
                    w_data_q[arcs_pkg::BIT_START] && !conversion_start_bit && !cif.busy;

  // ==========================================================================
  // Accumulation control
  assign next_acc = acc + arcs_pkg::sample_ext(data_sync, run_diff); // RULE3
  assign last_sample = (samples_left == 8'h01);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conversion_start_bit <= 1'b0;
      start_pulse <= 1'b0;
      acc <= '0;
      samples_left <= 8'h00;
      run_left <= 1'b0;
      run_diff <= 1'b0;
      run_count_log2 <= arcs_pkg::CNT_SEL_RESET;
      conversion_result <= 16'h0000;
    end else begin
      start_pulse <= 1'b0;
      if (sw_start) begin
        conversion_start_bit <= 1'b1;
        start_pulse <= 1'b1; // RULE13
        acc <= '0; // RULE16
        samples_left <= 8'(1 << sample_count_select); // RULE3
        run_left <= result_left_align;
        run_diff <= diff_mode;
        run_count_log2 <= sample_count_select;
      end else if (cif.done) begin
        acc <= next_acc; // RULE3
        samples_left <= samples_left - 8'h01;
        if (last_sample) begin
          conversion_result <= packed_result; // RULE14
          conversion_start_bit <= 1'b0;
        end else begin
          start_pulse <= 1'b1; // RULE15
        end
      end
    end
  end

  // ==========================================================================
  // Channel holding register and analog outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      positive_input_select <= arcs_pkg::SEL_RESET;
      negative_input_select <= arcs_pkg::SEL_RESET;
      analog_sample <= 1'b0;
    end else begin
      analog_sample <= cif.sampling;
      // Frozen from the start pulse so a late write cannot shorten sampling
      if (!cif.hold_sel && !start_pulse) begin // RULE9 RULE10 RULE11 RULE12
        positive_input_select <= pos_select;
        negative_input_select <= diff_mode ? neg_select : arcs_pkg::NEG_UNUSED; // RULE8
      end
    end
  end

  // ==========================================================================
  // Result ready flag and interrupt
  assign rd_fire = arvalid && arready;
  assign rd_clear_flag = rd_fire && (araddr == arcs_pkg::OFS_INT_STATUS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_ready_flag <= 1'b0;
      irq <= 1'b0;
    end else begin
      // Set wins over a clearing read in the same cycle
      if (cif.done && last_sample && !sw_start) begin
        result_ready_flag <= 1'b1; // RULE14
      end else if (rd_clear_flag) begin
        result_ready_flag <= 1'b0;
      end
      irq <= result_ready_flag && result_ready_mask;
    end
  end

  // ==========================================================================
  // AXI4-Lite read path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= arcs_pkg::RESP_OKAY;
    end else begin
      arready <= !arready && !rvalid && arvalid;
      if (rd_fire) begin
        rvalid <= 1'b1;
        rdata <= 32'h00000000;
        rresp <= arcs_pkg::RESP_OKAY;
        case (araddr)
          arcs_pkg::OFS_CONTROL_A: begin
            rdata[arcs_pkg::BIT_LEFT_ALIGN] <= result_left_align;
            rdata[arcs_pkg::BIT_DIFF_MODE] <= diff_mode;
          end
          arcs_pkg::OFS_CONTROL_B: rdata[arcs_pkg::CNT_SEL_W-1:0] <= sample_count_select;
          arcs_pkg::OFS_PRESCALE: rdata[arcs_pkg::PRESC_W-1:0] <= prescale;
          arcs_pkg::OFS_POS_SELECT: rdata[arcs_pkg::SEL_W-1:0] <= pos_select;
          arcs_pkg::OFS_NEG_SELECT: rdata[arcs_pkg::SEL_W-1:0] <= neg_select;
          arcs_pkg::OFS_COMMAND: rdata[arcs_pkg::BIT_START] <= conversion_start_bit; // RULE15
          arcs_pkg::OFS_RESULT: rdata[arcs_pkg::RES_W-1:0] <= conversion_result;
          arcs_pkg::OFS_INT_STATUS: rdata[arcs_pkg::BIT_RES_READY] <= result_ready_flag;
          arcs_pkg::OFS_INT_MASK: rdata[arcs_pkg::BIT_RES_READY] <= result_ready_mask;
          default: rresp <= arcs_pkg::RESP_SLVERR;
        endcase
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

endmodule // arcs_top

// file: verification/arcs_props.sv
// Port-level concurrent checks for the accumulating converter back end
`timescale 1ns/1ps
module arcs_props (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [7:0] araddr,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  // Analog front end and interrupt
  input wire logic [arcs_pkg::SEL_W-1:0] positive_input_select,
  input wire logic [arcs_pkg::SEL_W-1:0] negative_input_select,
  input wire logic analog_sample,
  input wire logic irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ==========================================================================
  // Sequences and properties
  sequence s_write_take;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_status_read;
    arvalid && arready && araddr == arcs_pkg::OFS_INT_STATUS;
  endsequence

  property p_write_resp;
    s_write_take |-> ##[1:2] bvalid;
  endproperty
  property p_read_resp;
    arvalid && arready |=> rvalid;
  endproperty
  property p_bvalid_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  property p_rvalid_hold;
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
  endproperty
  property p_awready_pulse;
    awready |=> !awready;
  endproperty
  property p_slverr_zero;
    rvalid && rresp == arcs_pkg::RESP_SLVERR |-> rdata == 32'h0;
  endproperty
  property p_sel_frozen;
    analog_sample |-> $stable(positive_input_select) && $stable(negative_input_select);
  endproperty
  property p_sample_len;
    $rose(analog_sample) |-> analog_sample [*3];
  endproperty
  property p_irq_clear;
    s_status_read ##0 irq |-> ##[1:4] !irq;
  endproperty

  // ==========================================================================
  // Assertions
  a_write_resp: assert property (p_write_resp) else $error("write response late");
  a_read_resp: assert property (p_read_resp) else $error("read data late");
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped");
  a_rvalid_hold: assert property (p_rvalid_hold) else $error("read data dropped");
  a_awready_pulse: assert property (p_awready_pulse) else $error("awready not a pulse");
  a_slverr_zero: assert property (p_slverr_zero) else $error("error read data not zero");
  a_sel_frozen: assert property (p_sel_frozen) else $error("selection moved in sampling");
  a_sample_len: assert property (p_sample_len) else $error("sampling window short");
  a_irq_clear: assert property (p_irq_clear) else $error("irq stuck after read");
endmodule // arcs_props

bind arcs_top arcs_props arcs_props_u (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
  .wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
  .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
  .rresp(rresp), .positive_input_select(positive_input_select),
  .negative_input_select(negative_input_select), .analog_sample(analog_sample), .irq(irq));

// file: verification/arcs_afe_model.sv
// Behavioural analog multiplexer and converter core facing the back end
`timescale 1ns/1ps
module arcs_afe_model (
  // Clock
  input wire logic aclk,
  // Applied selections and sampling strobe
  input wire logic [arcs_pkg::SEL_W-1:0] pos_sel,
  input wire logic [arcs_pkg::SEL_W-1:0] neg_sel,
  input wire logic sample,
  // Raw sample word
  output logic [arcs_pkg::RAW_W-1:0] data
);
  logic [arcs_pkg::RAW_W-1:0] held;

  // Word tells which channels were applied; held until the next sampling window
  initial held = 12'h000;
  always @(posedge aclk) begin
    if (sample) begin
      held <= {pos_sel[5:0], neg_sel[5:0]};
    end
  end
  assign data = held;
endmodule // arcs_afe_model

// file: verification/arcs_tb_top.sv
// Self-checking bench for the accumulating converter back end
`timescale 1ns/1ps
module arcs_tb_top;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, analog_sample, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [arcs_pkg::RAW_W-1:0] analog_data;
  logic [arcs_pkg::SEL_W-1:0] positive_input_select, negative_input_select;
  int miscompares = 0;
  int compares = 0;

  arcs_top dut_u (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .analog_data(analog_data),
    .positive_input_select(positive_input_select),
    .negative_input_select(negative_input_select), .analog_sample(analog_sample), .irq(irq));
  arcs_afe_model afe_u (.aclk(aclk), .pos_sel(positive_input_select),
    .neg_sel(negative_input_select), .sample(analog_sample), .data(analog_data));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // ==========================================================================
  // Reporting
  task print_verdict;
    $display("Comparisons %0d, mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task timed_out;
    miscompares++;
    $display("Error at %0t: wait ran out", $time);
    print_verdict();
  endtask

  // ==========================================================================
  // Register bus master
  task axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
      if (bvalid) bready <= 1'b1;
    end
    if (n == 100) timed_out();
    r = bresp;
    bready <= 1'b0;
  endtask

  task axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
      if (rvalid) rready <= 1'b1;
    end
    if (n == 100) timed_out();
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    check(r, arcs_pkg::RESP_OKAY);
  endtask

  task rd(input logic [7:0] a, output logic [31:0] d);
    logic [1:0] r;
    axi_read(a, d, r);
    check(r, arcs_pkg::RESP_OKAY);
  endtask

  // ==========================================================================
  // Expected packing and conversion helpers
  function automatic logic [15:0] exp_res(input logic [11:0] raw, input bit diff, left,
                                          input int sel);
    logic [18:0] s;
    s = {{7{diff & raw[11]}}, raw} << sel;
    if (sel > 4) return 16'(s >> (sel - 4));
    if (left) return 16'(s << (4 - sel));
    return s[15:0];
  endfunction

  task wait_idle;
    logic [31:0] d;
    int n;
    d = 32'h1;
    for (n = 0; n < 3000 && d[0] !== 1'b0; n++) rd(arcs_pkg::OFS_COMMAND, d);
    if (n == 3000) timed_out();
  endtask

  task run_conv(input bit diff, left, input int sel, input logic [6:0] pos, neg, input bit msk);
    logic [31:0] d;
    logic [11:0] raw;
    raw = diff ? {pos[5:0], neg[5:0]} : {pos[5:0], 6'h00};
    wr(arcs_pkg::OFS_CONTROL_A, {30'h0, diff, left});
    wr(arcs_pkg::OFS_CONTROL_B, 32'(sel));
    wr(arcs_pkg::OFS_POS_SELECT, {25'h0, pos});
    wr(arcs_pkg::OFS_NEG_SELECT, {25'h0, neg});
    wr(arcs_pkg::OFS_INT_MASK, {31'h0, msk});
    wr(arcs_pkg::OFS_COMMAND, 32'h1);
    rd(arcs_pkg::OFS_COMMAND, d);
    check(d, 32'h1);
    wait_idle();
    rd(arcs_pkg::OFS_RESULT, d);
    check(d, {16'h0, exp_res(raw, diff, left, sel)});
    check(negative_input_select, diff ? neg : 7'h00);
    repeat (2) @(posedge aclk);
    check(irq, msk);
    rd(arcs_pkg::OFS_INT_STATUS, d);
    check(d, 32'h1);
    rd(arcs_pkg::OFS_INT_STATUS, d);
    check(d, 32'h0);
    check(irq, 1'b0);
  endtask

  // ==========================================================================
  // Scenarios
  task t_regs;
    logic [31:0] d;
    logic [1:0] r;
    rd(arcs_pkg::OFS_RESULT, d);
    check(d, 32'h0);
    wr(arcs_pkg::OFS_RESULT, 32'h1234);
    rd(arcs_pkg::OFS_RESULT, d);
    check(d, 32'h0);
    wr(arcs_pkg::OFS_PRESCALE, 32'h5);
    rd(arcs_pkg::OFS_PRESCALE, d);
    check(d, 32'h5);
    wr(arcs_pkg::OFS_PRESCALE, 32'h0);
    wstrb <= 4'h0;
    wr(arcs_pkg::OFS_CONTROL_B, 32'h3);
    wstrb <= 4'hF;
    rd(arcs_pkg::OFS_CONTROL_B, d);
    check(d, 32'h0);
    axi_write(8'h40, 32'h1, r);
    check(r, arcs_pkg::RESP_SLVERR);
    axi_read(8'h40, d, r);
    check(r, arcs_pkg::RESP_SLVERR);
    check(d, 32'h0);
  endtask

  task t_freeze;
    logic [31:0] d;
    int n;
    wr(arcs_pkg::OFS_CONTROL_A, 32'h0);
    wr(arcs_pkg::OFS_CONTROL_B, 32'h0);
    wr(arcs_pkg::OFS_POS_SELECT, 32'h15);
    repeat (3) @(posedge aclk);
    check(positive_input_select, 7'h15);
    wr(arcs_pkg::OFS_COMMAND, 32'h1);
    for (n = 0; n < 50 && analog_sample !== 1'b1; n++) @(posedge aclk);
    check(analog_sample, 1'b1);
    wr(arcs_pkg::OFS_POS_SELECT, 32'h2A);
    check(positive_input_select, 7'h15);
    wait_idle();
    check(positive_input_select, 7'h2A);
    rd(arcs_pkg::OFS_RESULT, d);
    check(d, 32'h540);
    rd(arcs_pkg::OFS_INT_STATUS, d);
    check(d, 32'h1);
  endtask

  task t_counts;
    for (int s = 0; s < 8; s++) run_conv(1'b0, 1'b0, s, 7'h2B, 7'h11, s[0]);
  endtask

  task t_align;
    for (int s = 0; s < 6; s++) run_conv(1'b0, 1'b1, s, 7'h1D, 7'h00, 1'b1);
  endtask

  task t_diff;
    wr(arcs_pkg::OFS_PRESCALE, 32'h1);
    run_conv(1'b1, 1'b0, 0, 7'h3F, 7'h3E, 1'b0);
    run_conv(1'b1, 1'b0, 3, 7'h3F, 7'h3E, 1'b1);
    run_conv(1'b1, 1'b0, 3, 7'h3F, 7'h3E, 1'b1);
    run_conv(1'b1, 1'b1, 2, 7'h20, 7'h01, 1'b0);
    run_conv(1'b1, 1'b0, 6, 7'h05, 7'h07, 1'b1);
    run_conv(1'b1, 1'b1, 6, 7'h25, 7'h07, 1'b0);
  endtask

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_freeze();
    t_counts();
    t_align();
    t_diff();
    print_verdict();
  end
endmodule // arcs_tb_top
